//--- drc_consts.svh
// Constants for the differential restraint compensation block
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH
// Register byte addresses
`define DRC_A_CTRL     8'h00
`define DRC_A_GAIN_V   8'h04
`define DRC_A_GAIN_CT  8'h08
`define DRC_A_TAP      8'h0C
`define DRC_A_LVL_TRA  8'h10
`define DRC_A_LVL_STA  8'h14
`define DRC_A_INRUSH   8'h18
`define DRC_A_HOLD     8'h1C
`define DRC_A_OFFSET   8'h20
`define DRC_A_NEARZ    8'h24
`define DRC_A_CHAR_A   8'h28
`define DRC_A_CHAR_B   8'h2C
`define DRC_A_CHAR_C   8'h30
`define DRC_A_STATUS   8'h34
// Control fields
`define DRC_C_H2EN     0
`define DRC_C_H4EN     1
`define DRC_C_H5EN     2
`define DRC_C_SATEN    3
`define DRC_C_XBLK     4
`define DRC_C_ACB      5
`define DRC_C_G1       10:8
`define DRC_C_G2       14:12
`define DRC_C_SHIFT    19:16
`define DRC_CTRL_MASK  32'h000F_773F
// Generic slices
`define DRC_LO16       15:0
`define DRC_HI16       31:16
`define DRC_B0         7:0
`define DRC_B1         15:8
`define DRC_B2         23:16
`define DRC_K1         11:0
`define DRC_K2         27:16
// Reset values and arithmetic constants
`define DRC_ONE_Q12    16'h1000
`define DRC_PERCENT    32'h0000_0064
`define DRC_COS0       19'sh0_4000
`define DRC_COS30      19'sh0_376D
`define DRC_COS60      19'sh0_2000
`define DRC_THIRD_Q16  18'sh0_5555
`define DRC_SECTORS    5'h0C
`define DRC_SIN_SHIFT  5'h09
`define DRC_INT_SECOND 2'h1
// Timing
`define DRC_CLK_NS     32'h0000_0005
`define DRC_MS_NS      32'h000F_4240
`define DRC_TICK_CYCLES (`DRC_MS_NS / `DRC_CLK_NS)
`define DRC_BLOCK_MS   16'h03E8
`endif

//--- drc_pkg.sv
// Types for the differential restraint compensation block
`default_nettype none
package drc_pkg;
  typedef enum logic [1:0] {
    SAT_IDLE  = 2'b00,
    SAT_HOLD  = 2'b01,
    SAT_BLOCK = 2'b10
  } drc_sat_t;
  typedef enum logic [2:0] {
    GND_Y = 3'b000, GND_D = 3'b001, GND_Z = 3'b010, GND_YN = 3'b011, GND_ZN = 3'b100
  } drc_gnd_t;
endpackage : drc_pkg
`default_nettype wire

//--- drc_div_if.sv
// Handshake between the gain calculation and the divider
`timescale 1ns/1ps
`default_nettype none
interface drc_div_if;
  logic        start;
  logic [31:0] num;
  logic [15:0] den;
  logic        done;
  logic        busy;
  logic [31:0] quot;
  modport ctl (output start, num, den, input done, busy, quot);
  modport div (input start, num, den, output done, busy, quot);
endinterface : drc_div_if
`default_nettype wire

//--- drc_divider.sv
// Sequential restoring divider for the secondary gain
`timescale 1ns/1ps
`default_nettype none
module drc_divider (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  drc_div_if.div    dif
);
  logic [31:0] q;
  logic [16:0] rem;
  logic [5:0]  cnt;
  logic [16:0] trial;
  logic        done;

  // Shifted partial remainder for this step
  assign trial = {rem[15:0], q[31]};
  assign dif.busy = (cnt != 6'h00);
  assign dif.quot = q;
  assign dif.done = done;

  // One quotient bit per cycle; a new start restarts at once
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q    <= 32'h0000_0000;
      rem  <= 17'h0_0000;
      cnt  <= 6'h00;
      done <= 1'b0;
    end else if (dif.start) begin
      q    <= dif.num;
      rem  <= 17'h0_0000;
      cnt  <= 6'h20;
      done <= 1'b0;
    end else if (cnt != 6'h00) begin
      if (trial >= {1'b0, dif.den}) begin
        rem <= trial - {1'b0, dif.den};
        q   <= {q[30:0], 1'b1};
      end else begin
        rem <= trial;
        q   <= {q[30:0], 1'b0};
      end
      cnt  <= cnt - 6'h01;
      done <= (cnt == 6'h01);
    end else begin
      done <= 1'b0;
    end
  end
endmodule : drc_divider
`default_nettype wire

//--- drc_restraint.sv
// Winding compensation, temporary restraint and trip compare core
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "drc_consts.svh"
// Functional notes
// - Scale secondary by voltage, tap, CT ratios
// - Rotate secondary by vector group times 30 degrees
// - Phase sequence handled inside angle compensation
// - Remove zero sequence per grounded winding
// - Restraint raises trip threshold by offset
// - Harmonic trigger needs enable and level exceeded
// - Saturation trigger needs enable and external fault
// - Cross block restrains own or all phases
// - Inrush window uses transient second/fifth levels
// - After window, steady levels keep restraint
// - Zero crossing external fault starts restraint
// - Two internal crossings remove saturation restraint
// - Never start saturation restraint on internal fault
// - Hold limit timer ends saturation restraint
// - One second lockout after saturation removal
// - Trip on characteristic plus restraint offset
module drc_restraint
  import drc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `DRC_TICK_CYCLES
) (
  input  wire logic             CLK_I,
  input  wire logic             RESET_N_I,
  input  wire logic [7:0]       ADDR_I,
  input  wire logic [31:0]      WDATA_I,
  input  wire logic             WR_I,
  input  wire logic             RD_I,
  output logic      [31:0]      RDATA_O,
  input  wire logic             MEAS_VALID_I,
  input  wire logic [2:0][15:0] W1_RE_I,
  input  wire logic [2:0][15:0] W1_IM_I,
  input  wire logic [2:0][15:0] W2_RE_I,
  input  wire logic [2:0][15:0] W2_IM_I,
  output logic                  COMP_VALID_O,
  output logic      [2:0][15:0] W1_RE_O,
  output logic      [2:0][15:0] W1_IM_O,
  output logic      [2:0][15:0] W2_RE_O,
  output logic      [2:0][15:0] W2_IM_O,
  input  wire logic [2:0][7:0]  H2_PCT_I,
  input  wire logic [2:0][7:0]  H4_PCT_I,
  input  wire logic [2:0][7:0]  H5_PCT_I,
  input  wire logic [2:0][15:0] ID_I,
  input  wire logic [2:0][15:0] IS_I,
  input  wire logic [2:0]       ZERO_CROSS_I,
  input  wire logic             ENERGIZE_I,
  output logic      [2:0]       RESTRAINT_O,
  output logic      [2:0]       TRIP_O
);
  drc_div_if dif ();

  logic [31:0] ctrl, lvl_tra, lvl_sta, char_a, char_b, char_c;
  logic [15:0] gain_v, gain_ct, gain, inrush_ms, hold_ms, offset, near_zero;
  logic [7:0]  tap;
  logic        div_start;
  logic [31:0] tick_cnt;
  logic        tick;
  logic        en_s1, en_s2, en_s3;
  logic [15:0] inrush_left;
  logic        inrush_act;
  drc_sat_t    sat_st [3];
  logic [15:0] sat_tmr [3];
  logic [1:0]  int_cnt [3];
  logic [15:0] is_prev [3];
  logic [15:0] id_prev [3];
  logic [2:0]  ext, intl, sat_hold, sat_blk, harm, trig, next_restraint, next_trip;
  logic [21:0] thr [3];
  logic [7:0]  thr2, thr4, thr5;
  logic [3:0]  kk, ks;
  logic signed [18:0] cs, sn, g19;
  logic signed [15:0] s_re [3], s_im [3], r_re [3], r_im [3];
  logic signed [15:0] z1_re, z1_im, z2_re, z2_im;

  // Q14 product, keeps the integer part of a Q14 factor
  function automatic logic signed [15:0] mul14(input logic signed [15:0] a,
                                               input logic signed [18:0] b);
    logic signed [34:0] pr;
    pr = 35'(a) * 35'(b);
    return pr[29:14];
  endfunction : mul14

  // Zero-sequence component: one third of the phase sum
  function automatic logic signed [15:0] zseq(input logic signed [15:0] a,
                                              input logic signed [15:0] b,
                                              input logic signed [15:0] c);
    logic signed [17:0] s;
    logic signed [35:0] pr;
    s  = 18'(a) + 18'(b) + 18'(c);
    pr = 36'(s) * 36'(`DRC_THIRD_Q16);
    return pr[31:16];
  endfunction : zseq

  // Cosine of k times 30 degrees in Q14
  function automatic logic signed [18:0] cos30(input logic [3:0] k);
    case (k)
      4'h0:        return `DRC_COS0;
      4'h1, 4'hB:  return `DRC_COS30;
      4'h2, 4'hA:  return `DRC_COS60;
      4'h4, 4'h8:  return -(`DRC_COS60);
      4'h5, 4'h7:  return -(`DRC_COS30);
      4'h6:        return -(`DRC_COS0);
      default:     return 19'sh0_0000;
    endcase
  endfunction : cos30

  // Neutral grounded on this winding
  function automatic logic grounded(input logic [2:0] g);
    return (g == GND_YN) || (g == GND_ZN);
  endfunction : grounded

  // Slope term of the static characteristic, slope in Q4.8
  function automatic logic [19:0] slope(input logic [15:0] x, input logic [11:0] k);
    logic [27:0] pr;
    pr = 28'(x) * 28'(k);
    return pr[27:8];
  endfunction : slope

  // Register writes; reserved control bits are dropped
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl      <= 32'h0000_0000;
      gain_v    <= `DRC_ONE_Q12;
      gain_ct   <= `DRC_ONE_Q12;
      tap       <= 8'h00;
      lvl_tra   <= 32'h0000_0000;
      lvl_sta   <= 32'h0000_0000;
      inrush_ms <= 16'h0000;
      hold_ms   <= 16'h0000;
      offset    <= 16'h0000;
      near_zero <= 16'h0000;
      char_a    <= 32'h0000_0000;
      char_b    <= 32'h0000_0000;
      char_c    <= 32'h0000_0000;
    end else if (WR_I) begin
      case (ADDR_I)
        `DRC_A_CTRL:    ctrl      <= WDATA_I & `DRC_CTRL_MASK;
        `DRC_A_GAIN_V:  gain_v    <= WDATA_I[`DRC_LO16];
        `DRC_A_GAIN_CT: gain_ct   <= WDATA_I[`DRC_LO16];
        `DRC_A_TAP:     tap       <= WDATA_I[`DRC_B0];
        `DRC_A_LVL_TRA: lvl_tra   <= {16'h0000, WDATA_I[`DRC_LO16]};
        `DRC_A_LVL_STA: lvl_sta   <= {8'h00, WDATA_I[23:0]};
        `DRC_A_INRUSH:  inrush_ms <= WDATA_I[`DRC_LO16];
        `DRC_A_HOLD:    hold_ms   <= WDATA_I[`DRC_LO16];
        `DRC_A_OFFSET:  offset    <= WDATA_I[`DRC_LO16];
        `DRC_A_NEARZ:   near_zero <= WDATA_I[`DRC_LO16];
        `DRC_A_CHAR_A:  char_a    <= WDATA_I;
        `DRC_A_CHAR_B:  char_b    <= WDATA_I;
        `DRC_A_CHAR_C:  char_c    <= WDATA_I & 32'h0FFF_0FFF;
        default:        ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (!RD_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      case (ADDR_I)
        `DRC_A_CTRL:    RDATA_O <= ctrl;
        `DRC_A_GAIN_V:  RDATA_O <= {16'h0000, gain_v};
        `DRC_A_GAIN_CT: RDATA_O <= {16'h0000, gain_ct};
        `DRC_A_TAP:     RDATA_O <= {gain, 8'h00, tap};
        `DRC_A_LVL_TRA: RDATA_O <= lvl_tra;
        `DRC_A_LVL_STA: RDATA_O <= lvl_sta;
        `DRC_A_INRUSH:  RDATA_O <= {16'h0000, inrush_ms};
        `DRC_A_HOLD:    RDATA_O <= {16'h0000, hold_ms};
        `DRC_A_OFFSET:  RDATA_O <= {16'h0000, offset};
        `DRC_A_NEARZ:   RDATA_O <= {16'h0000, near_zero};
        `DRC_A_CHAR_A:  RDATA_O <= char_a;
        `DRC_A_CHAR_B:  RDATA_O <= char_b;
        `DRC_A_CHAR_C:  RDATA_O <= char_c;
        `DRC_A_STATUS:  RDATA_O <= {18'h0_0000, dif.busy, sat_blk, sat_hold, TRIP_O,
                                    RESTRAINT_O, inrush_act};
        default:        RDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // Gain recalculates after any ratio or tap write; old gain used meanwhile
  assign dif.start = div_start;
  assign dif.num   = 32'((32'(gain_v) * 32'(gain_ct)) >> 12) * `DRC_PERCENT;
  assign dif.den   = 16'(`DRC_PERCENT) + {{8{tap[7]}}, tap};

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_start <= 1'b0;
      gain      <= `DRC_ONE_Q12;
    end else begin
      div_start <= WR_I && (ADDR_I == `DRC_A_GAIN_V || ADDR_I == `DRC_A_GAIN_CT ||
                            ADDR_I == `DRC_A_TAP);
      if (dif.done) begin
        gain <= (dif.quot[31:16] != 16'h0000) ? 16'hFFFF : dif.quot[`DRC_LO16];
      end
    end
  end

  drc_divider u_div (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .dif       (dif)
  );

  // Rotation sector; negative sequence turns the other way
  always_comb begin
    kk = ctrl[`DRC_C_SHIFT];
    if (ctrl[`DRC_C_ACB] && kk != 4'h0) begin
      kk = 4'(`DRC_SECTORS - 5'(kk));
    end
    ks  = 4'((5'(kk) + `DRC_SIN_SHIFT) % `DRC_SECTORS);
    cs  = cos30(kk);
    sn  = cos30(ks);
    g19 = $signed({1'b0, gain, 2'b00});
    for (int p = 0; p < 3; p++) begin
      s_re[p] = mul14($signed(W2_RE_I[p]), g19);
      s_im[p] = mul14($signed(W2_IM_I[p]), g19);
      r_re[p] = mul14(s_re[p], cs) - mul14(s_im[p], sn);
      r_im[p] = mul14(s_re[p], sn) + mul14(s_im[p], cs);
    end
    z1_re = zseq(W1_RE_I[0], W1_RE_I[1], W1_RE_I[2]);
    z1_im = zseq(W1_IM_I[0], W1_IM_I[1], W1_IM_I[2]);
    z2_re = zseq(r_re[0], r_re[1], r_re[2]);
    z2_im = zseq(r_im[0], r_im[1], r_im[2]);
  end

  // Compensated phasors register on each measurement strobe
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      COMP_VALID_O <= 1'b0;
      W1_RE_O      <= '0;
      W1_IM_O      <= '0;
      W2_RE_O      <= '0;
      W2_IM_O      <= '0;
    end else begin
      COMP_VALID_O <= MEAS_VALID_I;
      if (MEAS_VALID_I) begin
        for (int p = 0; p < 3; p++) begin
          W1_RE_O[p] <= grounded(ctrl[`DRC_C_G1]) ? W1_RE_I[p] - z1_re : W1_RE_I[p];
          W1_IM_O[p] <= grounded(ctrl[`DRC_C_G1]) ? W1_IM_I[p] - z1_im : W1_IM_I[p];
          W2_RE_O[p] <= grounded(ctrl[`DRC_C_G2]) ? r_re[p] - z2_re : r_re[p];
          W2_IM_O[p] <= grounded(ctrl[`DRC_C_G2]) ? r_im[p] - z2_im : r_im[p];
        end
      end
    end
  end

  // Millisecond tick for all restraint timers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt + 32'h1;
    end
  end

  // Energize pin is asynchronous, so it passes two flops first
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      en_s1       <= 1'b0;
      en_s2       <= 1'b0;
      en_s3       <= 1'b0;
      inrush_left <= 16'h0000;
    end else begin
      en_s1 <= ENERGIZE_I;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      if (en_s2 && !en_s3) begin
        inrush_left <= inrush_ms;
      end else if (tick && inrush_left != 16'h0000) begin
        inrush_left <= inrush_left - 16'h0001;
      end
    end
  end
  assign inrush_act = (inrush_left != 16'h0000);

  // Harmonic triggers; second and fifth levels switch when the inrush window closes, fourth always steady
  always_comb begin
    thr2 = inrush_act ? lvl_tra[`DRC_B0] : lvl_sta[`DRC_B0];
    thr5 = inrush_act ? lvl_tra[`DRC_B1] : lvl_sta[`DRC_B2];
    thr4 = lvl_sta[`DRC_B1];
    for (int p = 0; p < 3; p++) begin
      harm[p] = (ctrl[`DRC_C_H2EN] && H2_PCT_I[p] > thr2) ||
                (ctrl[`DRC_C_H4EN] && H4_PCT_I[p] > thr4) ||
                (ctrl[`DRC_C_H5EN] && H5_PCT_I[p] > thr5);
      ext[p]  = ZERO_CROSS_I[p] && IS_I[p] > is_prev[p] && ID_I[p] <= near_zero;
      intl[p] = ZERO_CROSS_I[p] && IS_I[p] > is_prev[p] && ID_I[p] > id_prev[p];
      sat_hold[p] = (sat_st[p] == SAT_HOLD);
      sat_blk[p]  = (sat_st[p] == SAT_BLOCK);
    end
    trig = harm | sat_hold;
    next_restraint = ctrl[`DRC_C_XBLK] ? {3{|trig}} : trig;
  end

  // Saturation restraint per phase: hold, then lockout
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int p = 0; p < 3; p++) begin
        sat_st[p]  <= SAT_IDLE;
        sat_tmr[p] <= 16'h0000;
        int_cnt[p] <= 2'h0;
        is_prev[p] <= 16'h0000;
        id_prev[p] <= 16'h0000;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (ZERO_CROSS_I[p]) begin
          is_prev[p] <= IS_I[p];
          id_prev[p] <= ID_I[p];
        end
        unique case (sat_st[p])
          SAT_IDLE: begin
            sat_tmr[p] <= 16'h0000;
            int_cnt[p] <= 2'h0;
            if (ctrl[`DRC_C_SATEN] && ext[p] && !intl[p]) begin
              sat_st[p] <= SAT_HOLD;
            end
          end
          SAT_HOLD: begin
            if (tick) begin
              sat_tmr[p] <= sat_tmr[p] + 16'h0001;
            end
            if (intl[p]) begin
              int_cnt[p] <= int_cnt[p] + 2'h1;
            end else if (ZERO_CROSS_I[p]) begin
              int_cnt[p] <= 2'h0; // any other crossing restarts the internal crossing count
            end
            if (!ctrl[`DRC_C_SATEN] || sat_tmr[p] >= hold_ms ||
                (intl[p] && int_cnt[p] == `DRC_INT_SECOND)) begin
              sat_st[p]  <= SAT_BLOCK;
              sat_tmr[p] <= 16'h0000;
            end
          end
          SAT_BLOCK: begin
            if (tick) begin
              sat_tmr[p] <= sat_tmr[p] + 16'h0001;
            end
            if (sat_tmr[p] >= `DRC_BLOCK_MS) begin
              sat_st[p] <= SAT_IDLE;
            end
          end
          default: sat_st[p] <= SAT_IDLE;
        endcase
      end
    end
  end

  // Static characteristic, plus offset on restrained phases; regions set by stabilizing current
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (IS_I[p] < char_b[`DRC_HI16]) begin
        thr[p] = 22'(char_a[`DRC_HI16]) + 22'(slope(IS_I[p], char_c[`DRC_K1]));
        if (thr[p] < 22'(char_a[`DRC_LO16])) begin
          thr[p] = 22'(char_a[`DRC_LO16]);
        end
      end else begin
        thr[p] = 22'(char_b[`DRC_LO16]) +
                 22'(slope(IS_I[p] - char_b[`DRC_HI16], char_c[`DRC_K2]));
      end
      if (RESTRAINT_O[p]) begin
        thr[p] = thr[p] + 22'(offset);
      end
      next_trip[p] = (22'(ID_I[p]) >= thr[p]);
    end
  end

  // Restraint and trip flags
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RESTRAINT_O <= 3'h0;
      TRIP_O      <= 3'h0;
    end else begin
      RESTRAINT_O <= next_restraint;
      TRIP_O      <= next_trip;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  property p_cross;
    ctrl[`DRC_C_XBLK] && (|trig) |=> RESTRAINT_O == 3'h7;
  endproperty
  a_cross: assert property (p_cross) else $error("cross block not applied");

  property p_harm_off;
    !ctrl[`DRC_C_H2EN] && !ctrl[`DRC_C_H4EN] && !ctrl[`DRC_C_H5EN] && sat_hold == 3'h0
      |=> RESTRAINT_O == 3'h0;
  endproperty
  a_harm_off: assert property (p_harm_off) else $error("restraint without trigger");

  property p_inrush;
    inrush_act && ctrl[`DRC_C_H2EN] && H2_PCT_I[0] > lvl_tra[`DRC_B0] |=> RESTRAINT_O[0];
  endproperty
  a_inrush: assert property (p_inrush) else $error("inrush level ignored");

  property p_sat_off;
    !ctrl[`DRC_C_SATEN] && sat_hold == 3'h0 |=> sat_hold == 3'h0;
  endproperty
  a_sat_off: assert property (p_sat_off) else $error("saturation hold while off");

  property p_no_int;
    sat_st[0] == SAT_IDLE && intl[0] |=> sat_st[0] != SAT_HOLD;
  endproperty
  a_no_int: assert property (p_no_int) else $error("hold started on internal fault");

  property p_hold_lim;
    sat_st[0] == SAT_HOLD && sat_tmr[0] >= hold_ms |=> sat_st[0] == SAT_BLOCK;
  endproperty
  a_hold_lim: assert property (p_hold_lim) else $error("hold limit not enforced");

  property p_two_int;
    sat_st[0] == SAT_HOLD && intl[0] && int_cnt[0] == `DRC_INT_SECOND
      |=> sat_st[0] == SAT_BLOCK ##1 (!RESTRAINT_O[0] || $past(harm[0]) || ctrl[`DRC_C_XBLK]);
  endproperty
  a_two_int: assert property (p_two_int) else $error("internal fault kept hold");

  property p_block;
    sat_st[0] == SAT_BLOCK && sat_tmr[0] < `DRC_BLOCK_MS |=> sat_st[0] == SAT_BLOCK;
  endproperty
  a_block: assert property (p_block) else $error("lockout ended early");

  property p_trip;
    RESTRAINT_O[0] && 22'(ID_I[0]) < 22'(offset) |=> !TRIP_O[0];
  endproperty
  a_trip: assert property (p_trip) else $error("trip below restraint offset");
endmodule : drc_restraint
`default_nettype wire

//--- drc_frontend.sv
// Measurement front end model delivering winding phasors
`timescale 1ns/1ps
`default_nettype none
module drc_frontend (
  input  wire logic             clk_i,
  output logic                  meas_valid_o,
  output logic      [2:0][15:0] w1_re_o,
  output logic      [2:0][15:0] w1_im_o,
  output logic      [2:0][15:0] w2_re_o,
  output logic      [2:0][15:0] w2_im_o
);
  initial begin
    meas_valid_o = 1'b0;
    {w1_re_o, w1_im_o, w2_re_o, w2_im_o} = '1;
  end
  // One strobe a set; afterwards the lines show the inverse so stale data never looks valid
  task automatic send(input logic [2:0][15:0] a, input logic [2:0][15:0] b,
                      input logic [2:0][15:0] c, input logic [2:0][15:0] d);
    @(posedge clk_i);
    meas_valid_o <= 1'b1;
    {w1_re_o, w1_im_o, w2_re_o, w2_im_o} <= {a, b, c, d};
    @(posedge clk_i);
    meas_valid_o <= 1'b0;
    {w1_re_o, w1_im_o, w2_re_o, w2_im_o} <= ~{a, b, c, d};
  endtask : send
endmodule : drc_frontend
`default_nettype wire

//--- diff_restraint_compensation_test.sv
// Self-checking bench for the restraint compensation core
`timescale 1ns/1ps
`default_nettype none
`include "drc_consts.svh"
module diff_restraint_compensation_test;
  logic             clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ener = 1'b0;
  logic             mv, cv;
  logic [7:0]       addr = '0;
  logic [31:0]      wdata = '0, rdata;
  logic [2:0]       zc = '0, rsn, trip;
  logic [2:0][7:0]  h2 = '0, h4 = '0, h5 = '0;
  logic [2:0][15:0] id = '0, ist = '0, a, b, c, d, o1r, o1i, o2r, o2i;
  int               fails = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  drc_frontend fe (.clk_i(clk), .meas_valid_o(mv), .w1_re_o(a), .w1_im_o(b), .w2_re_o(c),
                   .w2_im_o(d));
  // Short millisecond tick keeps the one second lockout within the run
  drc_restraint #(.TICK_CYCLES(10)) dut (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .MEAS_VALID_I(mv),
    .W1_RE_I(a), .W1_IM_I(b), .W2_RE_I(c), .W2_IM_I(d), .COMP_VALID_O(cv), .W1_RE_O(o1r),
    .W1_IM_O(o1i), .W2_RE_O(o2r), .W2_IM_O(o2i), .H2_PCT_I(h2), .H4_PCT_I(h4), .H5_PCT_I(h5),
    .ID_I(id), .IS_I(ist), .ZERO_CROSS_I(zc), .ENERGIZE_I(ener), .RESTRAINT_O(rsn),
    .TRIP_O(trip));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    {addr, wdata, wr_s} <= {ad, dt, 1'b1};
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk);
    {addr, rd_s} <= {ad, 1'b1};
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdchk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic xing(input logic [15:0] di, input logic [15:0] si, input logic [2:0] exp);
    @(posedge clk);
    {id, ist, zc} <= {{3{di}}, {3{si}}, 3'b111};
    @(posedge clk);
    zc <= 3'b000;
    wt(2);
    chk(rsn, exp);
  endtask : xing
  task automatic t_regs;
    rdchk(`DRC_A_GAIN_V, 32'h0000_1000);
    rdchk(8'h40, 32'h0000_0000);
    wr(`DRC_A_CTRL, 32'hFFFF_FFFF);
    rdchk(`DRC_A_CTRL, `DRC_CTRL_MASK);
    wr(`DRC_A_CTRL, 32'h0000_0000);
  endtask : t_regs
  // Gain 2.0 keeps the matching factors well inside the allowed spread
  task automatic t_comp;
    wr(`DRC_A_GAIN_V, 32'h0000_2000);
    wt(60);
    rdchk(`DRC_A_TAP, 32'h2000_0000);
    fe.send({16'h0, 16'h0, 16'h0300}, '0, {3{16'h0100}}, '0);
    #1 chk(o2r[0], 16'h0200);
    chk(cv, 1'b1);
    wr(`DRC_A_CTRL, 32'h0003_0300);
    fe.send({16'h0, 16'h0, 16'h0300}, '0, {3{16'h0100}}, '0);
    #1 chk(o2i[0], 16'h0200);
    chk(o1r[1][15], 1'b1);
    wr(`DRC_A_CTRL, 32'h0003_0020);
    fe.send('0, '0, {3{16'h0100}}, '0);
    #1 chk(o2i[0], 16'hFE00);
  endtask : t_comp
  task automatic t_harm;
    wr(`DRC_A_LVL_STA, 32'h0014_1414);
    for (int k = 0; k < 3; k++) begin
      wr(`DRC_A_CTRL, 32'h1 << k);
      {h2, h4, h5} <= {(k == 0) ? 24'h15 : 24'h0, (k == 1) ? 24'h15 : 24'h0,
                       (k == 2) ? 24'h15 : 24'h0};
      wt(3);
      chk(rsn, 3'b001);
      @(posedge clk);
      {h2, h4, h5} <= {3{24'h14}};
      wt(3);
      chk(rsn, 3'b000);
    end
    wr(`DRC_A_CTRL, 32'h0000_0011);
    h2 <= 24'h1E_0000;
    wt(3);
    chk(rsn, 3'b111);
    rdchk(`DRC_A_STATUS, 32'h0000_007E);
    wr(`DRC_A_CTRL, 32'h0000_0010);
    wt(3);
    chk(rsn, 3'b000);
  endtask : t_harm
  task automatic t_trip;
    wr(`DRC_A_CHAR_A, 32'h0100_0100);
    wr(`DRC_A_CHAR_B, 32'h0100_1000);
    wr(`DRC_A_OFFSET, 32'h0000_0080);
    {h2, id} <= {24'h0, {3{16'h0140}}};
    wt(4);
    chk(trip, 3'b111);
    wr(`DRC_A_CTRL, 32'h0000_0011);
    h2 <= 24'h1E;
    wt(4);
    chk(trip, 3'b000);
    @(posedge clk);
    id <= {3{16'h0180}};
    wt(4);
    chk(trip, 3'b111);
    @(posedge clk);
    {h2, id} <= '0;
  endtask : t_trip
  task automatic t_inrush;
    wr(`DRC_A_LVL_TRA, 32'h0000_3232);
    wr(`DRC_A_INRUSH, 32'h0000_0005);
    wr(`DRC_A_CTRL, 32'h0000_0001);
    ener <= 1'b1;
    wt(6);
    @(posedge clk);
    h2 <= 24'h1E;
    wt(3);
    chk(rsn, 3'b000);
    @(posedge clk);
    h2 <= 24'h33;
    wt(3);
    chk(rsn, 3'b001);
    @(posedge clk);
    h2 <= 24'h1E;
    wt(60);
    chk(rsn, 3'b001);
    @(posedge clk);
    {h2, ener} <= '0;
  endtask : t_inrush
  task automatic t_sat;
    wr(`DRC_A_NEARZ, 32'h0000_0010);
    wr(`DRC_A_HOLD, 32'h0000_0002);
    wr(`DRC_A_CTRL, 32'h0000_0008);
    xing(16'h0008, 16'h0100, 3'b000);
    xing(16'h0000, 16'h0200, 3'b111);
    wt(10);
    chk(rsn, 3'b111);
    wt(20);
    chk(rsn, 3'b000);
    xing(16'h0000, 16'h0300, 3'b000);
    wt(10050);
    xing(16'h0000, 16'h0400, 3'b111);
    xing(16'h0100, 16'h0500, 3'b111);
    xing(16'h0200, 16'h0600, 3'b000);
  endtask : t_sat
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_comp();
    t_harm();
    t_trip();
    t_inrush();
    t_sat();
    report_and_stop();
  end
  // Whole run is near 10350 cycles; a hang past 80000 cycles is counted as a failure
  initial begin
    #400_000;
    fails++;
    report_and_stop();
  end
endmodule : diff_restraint_compensation_test
`default_nettype wire
